// ==== testbench/odc_checker.sv ====
// Port assertions of the opcode decode classifier
`timescale 1ns/1ps
module odc_checker
	import odc_pkg::*;
#(
	parameter int NSLOT = 2
) (
	input wire logic                                          CLK,
	input wire logic                                          ARST_N,
	input wire logic [NSLOT-1:0][BYTES_W*8-1:0]               IN_BYTES,
	input wire logic                                          OUT_READY,
	input wire logic [NSLOT-1:0]                              TAKEN,
	input wire logic [NSLOT-1:0]                              OUT_VALID,
	input wire odc_pkg::odc_class_t [NSLOT-1:0]               OUT_CLASS,
	input wire odc_pkg::odc_optype_t [NSLOT-1:0][NUM_OPS-1:0] OUT_OPS,
	input wire logic [NSLOT-1:0][NUM_OPS-1:0][7:0]            OUT_UNITS,
	input wire logic [NSLOT-1:0]                              OUT_MEMFORM,
	input wire logic [NSLOT-1:0][2:0]                         OUT_REG_FIRST
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!ARST_N);
	sequence s_take(logic [7:0] op);
		TAKEN[0] && $past(IN_BYTES[0][7:0]) == op;
	endsequence
	sequence s_held;
		OUT_VALID[0] && !OUT_READY;
	endsequence
	slot_pair_a: assert property (OUT_VALID[1] |-> OUT_VALID[0]
		&& OUT_CLASS[0] == CLS_SHORT && OUT_CLASS[1] == CLS_SHORT)
		else $error("second slot beside a non-short slot");
	mem_form_a: assert property (s_take(OP_GRP_S) |-> OUT_MEMFORM[0] == ($past(IN_BYTES[0][15:14]) != MOD_REG))
		else $error("memory form flag wrong");
	reg_first_a: assert property (s_take(OP_GRP_S) |-> OUT_REG_FIRST[0] == $past(IN_BYTES[0][13:11]))
		else $error("first register index wrong");
	alux_unit_a: assert property (OUT_VALID[0] && OUT_OPS[0][0] == OPT_ALUX |-> OUT_UNITS[0][0] == UNIT_INTX)
		else $error("restricted op not on X unit");
	store_route_a: assert property (OUT_VALID[0] && OUT_OPS[0][2] == OPT_STORE
		|-> OUT_UNITS[0][2] == UNIT_STORE && OUT_OPS[0][0] == OPT_LOAD && OUT_UNITS[0][0] == UNIT_LOAD
		&& OUT_CLASS[0] == CLS_LONG)
		else $error("load op store sequence wrong");
	adc_vector_a: assert property (TAKEN[0] && $past(IN_BYTES[0][7:3]) == 5'h02 && $past(IN_BYTES[0][2:0]) < 3'h6
		|-> OUT_CLASS[0] == CLS_VECTOR)
		else $error("carry add not vector");
	add_short_a: assert property (s_take(OP_GRP_S) ##0 ($past(IN_BYTES[0][15:11]) == {MOD_REG, REG_ADD})
		|-> OUT_CLASS[0] == CLS_SHORT && OUT_OPS[0][0] == OPT_ALUX && OUT_OPS[0][1] == OPT_NONE)
		else $error("short add form wrong");
	hold_stable_a: assert property (s_held |=> OUT_VALID[0] && !TAKEN[0] && $stable(OUT_OPS[0]))
		else $error("held output changed");
endmodule
bind odc_decoder odc_checker #(.NSLOT(NSLOT)) i_chk (.CLK(CLK), .ARST_N(ARST_N), .IN_BYTES(IN_BYTES),
	.OUT_READY(OUT_READY), .TAKEN(TAKEN), .OUT_VALID(OUT_VALID), .OUT_CLASS(OUT_CLASS), .OUT_OPS(OUT_OPS),
	.OUT_UNITS(OUT_UNITS), .OUT_MEMFORM(OUT_MEMFORM), .OUT_REG_FIRST(OUT_REG_FIRST));

// ==== testbench/odc_sched_model.sv ====
// Scheduler model that accepts or stalls decoded slots
`timescale 1ns/1ps
module odc_sched_model (
	input  wire logic CLK,
	input  wire logic ARST_N,
	input  wire logic STALL,
	output logic      OUT_READY
);
	// Acceptance changes just after a rising edge
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			OUT_READY <= 1'b1;
		end else begin
			OUT_READY <= !STALL;
		end
	end
endmodule

// ==== testbench/test_odc_decoder.sv ====
// Self-checking bench of the opcode decode classifier
`timescale 1ns/1ps
module test_odc_decoder;
	import odc_pkg::*;
	logic                      clk;
	logic                      arst_n;
	logic                      stall;
	logic                      rdy;
	logic [1:0]                iv;
	logic [1:0][BYTES_W*8-1:0] ib;
	logic [1:0]                o32;
	logic [1:0]                a32;
	logic [1:0]                tk;
	logic [1:0]                vld;
	odc_class_t [1:0]          cls;
	odc_optype_t [1:0][2:0]    ops;
	logic [1:0][2:0][7:0]      un;
	logic [1:0]                unr;
	logic [1:0]                mf;
	logic [1:0][2:0]           rf;
	logic [1:0][2:0]           rs;
	logic [1:0][31:0]          imm;
	logic [1:0][31:0]          dsp;
	logic [2:0]                st;
	int                        fails;
	int                        num_checks;
	odc_decoder i_dut (.CLK(clk), .ARST_N(arst_n), .IN_VALID(iv), .IN_BYTES(ib), .OP_SIZE32(o32),
		.ADDR_SIZE32(a32), .OUT_READY(rdy), .TAKEN(tk), .OUT_VALID(vld), .OUT_CLASS(cls), .OUT_OPS(ops),
		.OUT_UNITS(un), .OUT_UNRECOG(unr), .OUT_MEMFORM(mf), .OUT_REG_FIRST(rf), .OUT_REG_SECOND(rs),
		.OUT_IMM(imm), .OUT_DISP(dsp), .OUT_STATE(st));
	odc_sched_model i_sched (.CLK(clk), .ARST_N(arst_n), .STALL(stall), .OUT_READY(rdy));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic chk(input logic [39:0] g, input logic [39:0] e);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic report_and_stop();
		if (fails == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic wt();
		int n;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (tk[0] !== 1'b1 && n < 9);
		if (tk[0] !== 1'b1) begin
			fails++;
			report_and_stop();
		end
	endtask
	// Slot 0 request; valid stays up for back-to-back use
	task automatic dec(input logic [7:0] op, input logic [7:0] m, input logic [31:0] d, input logic o, input logic a);
		ib[0] = {80'h0, d, m, op};
		o32[0] = o;
		a32[0] = a;
		iv = 2'b01;
		wt();
	endtask
	task automatic t_adjust();
		logic [15:0] v [5] = '{16'h0037, 16'h003f, 16'h0ad5, 16'h0ad4, 16'h0bd5};
		foreach (v[i]) begin
			dec(v[i][7:0], v[i][15:8], 32'h0, 1'b1, 1'b1);
			chk({unr[0], cls[0]}, i < 4 ? 3'h3 : 3'h4);
		end
	endtask
	task automatic t_adc();
		logic [7:0] o [9] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, OP_GRP_B, OP_GRP_V, OP_GRP_S};
		for (int i = 0; i < 18; i++) begin
			dec(o[i % 9], {i < 9 ? MOD_REG : MOD_D8, REG_ADC, 3'h1}, 32'h0, 1'b1, 1'b1);
			chk(cls[0], CLS_VECTOR);
		end
	endtask
	// Opcode, modR/M, class, op list, unit masks
	task automatic t_ops();
		logic [55:0] t [6] = '{{16'h83c0, 4'h1, 12'h002, 24'h000001}, {16'h0345, 4'h1, 12'h016, 24'h000308},
			{16'h0145, 4'h2, 12'ha16, 24'h100308}, {16'h2007, 4'h2, 12'ha26, 24'h100108},
			{16'h22c8, 4'h1, 12'h002, 24'h000001}, {16'h0500, 4'h1, 12'h001, 24'h000003}};
		foreach (t[i]) begin
			dec(t[i][55:48], t[i][47:40], 32'h0, 1'b1, 1'b1);
			chk({cls[0], ops[0]}, t[i][39:24]);
			chk(un[0], t[i][23:0]);
		end
	endtask
	task automatic t_fields();
		dec(8'h01, 8'he9, 32'h0, 1'b1, 1'b1);
		chk({mf[0], rf[0], rs[0]}, 7'h29);
		dec(8'h83, 8'hc0, 32'hf0, 1'b1, 1'b1);
		chk(imm[0], 32'hfffffff0);
		dec(8'h81, 8'hc0, 32'h12345678, 1'b1, 1'b1);
		chk(imm[0], 32'h12345678);
		dec(8'h81, 8'hc0, 32'h12345678, 1'b0, 1'b1);
		chk(imm[0], 32'h5678);
		dec(8'h80, 8'hc0, 32'h789a, 1'b1, 1'b1);
		chk(imm[0], 32'h9a);
		dec(8'h01, 8'h45, 32'h80, 1'b1, 1'b1);
		chk({mf[0], dsp[0]}, 33'h1ffffff80);
		dec(8'h01, 8'h80, 32'h89abcdef, 1'b1, 1'b1);
		chk(dsp[0], 32'h89abcdef);
		dec(8'h01, 8'h80, 32'h89abcdef, 1'b1, 1'b0);
		chk(dsp[0], 32'hcdef);
	endtask
	task automatic t_pair();
		ib = {{80'h0, 32'h0, 8'hd1, 8'h01}, {80'h0, 32'h0, 8'hc8, 8'h03}};
		iv = 2'b11;
		wt();
		chk({tk, vld}, 4'hf);
		ib[0] = {80'h0, 32'h0, 8'h45, 8'h01};
		wt();
		chk({tk, vld, cls[0]}, {4'h5, CLS_LONG});
	endtask
	task automatic t_hold();
		iv = 2'b00;
		stall = 1'b1;
		repeat (2) @(negedge clk);
		dec(8'h05, 8'h0, 32'h7, 1'b1, 1'b1);
		repeat (3) begin
			@(negedge clk);
			chk({vld[0], tk[0], st}, 5'h14);
		end
		stall = 1'b0;
		repeat (3) @(negedge clk);
		iv = 2'b00;
	endtask
	initial begin
		arst_n = 1'b0;
		stall = 1'b0;
		iv = 2'b00;
		ib = '0;
		o32 = 2'b11;
		a32 = 2'b11;
		fails = 0;
		num_checks = 0;
		repeat (3) @(negedge clk);
		arst_n = 1'b1;
		chk({vld, st}, 5'h01);
		@(negedge clk);
		t_adjust();
		t_adc();
		t_ops();
		t_fields();
		t_pair();
		t_hold();
		report_and_stop();
	end
endmodule

// ==== verilog/odc_decoder.sv ====
// Two-slot opcode decode classifier with per-clock issue limit
//
// Summary of operation
// - Per clock: two short, one long, or vector.
// - Mod 11 is register form, else memory.
// - First media/reg operand from modR/M 5:3.
// - Second media operand from modR/M 2:0.
// - X-restricted ops go only to X unit.
// - General ALU ops go to either unit.
// - Route each operation type to its unit.
// - Every add-with-carry form decodes as vector.
// - 83h add register form: short, one alux.
// - Memory destination long; memory source short with load.
// - Adjust opcodes vector; D4h/D5h need 0Ah.
// - Immediates 8 bits, or 16/32 by operand size.
// - Displacements 8 bits, or 16/32 by address size.
`timescale 1ns/1ps
module odc_decoder
	import odc_pkg::*;
#(
	parameter int NSLOT = 2
) (
	input  wire logic                     CLK,
	input  wire logic                     ARST_N,
	input  wire logic [NSLOT-1:0]         IN_VALID,
	input  wire logic [NSLOT-1:0][BYTES_W*8-1:0] IN_BYTES,
	input  wire logic [NSLOT-1:0]         OP_SIZE32,
	input  wire logic [NSLOT-1:0]         ADDR_SIZE32,
	input  wire logic                     OUT_READY,
	output logic      [NSLOT-1:0]         TAKEN,
	output logic      [NSLOT-1:0]         OUT_VALID,
	output odc_pkg::odc_class_t [NSLOT-1:0] OUT_CLASS,
	output odc_pkg::odc_optype_t [NSLOT-1:0][NUM_OPS-1:0] OUT_OPS,
	output logic [NSLOT-1:0][NUM_OPS-1:0][7:0] OUT_UNITS,
	output logic      [NSLOT-1:0]         OUT_UNRECOG,
	output logic      [NSLOT-1:0]         OUT_MEMFORM,
	output logic      [NSLOT-1:0][2:0]    OUT_REG_FIRST,
	output logic      [NSLOT-1:0][2:0]    OUT_REG_SECOND,
	output logic      [NSLOT-1:0][31:0]   OUT_IMM,
	output logic      [NSLOT-1:0][31:0]   OUT_DISP,
	output logic      [2:0]               OUT_STATE
);
	import odc_pkg::*;

	typedef struct packed {
		logic       vld;
		odc_class_t cls;
		odc_optype_t [NUM_OPS-1:0] ops;
		logic [NUM_OPS-1:0][7:0] units;
		logic       unrec;
		logic       mem;
		logic [2:0] rf;
		logic [2:0] rs;
		logic [31:0] imm;
		logic [31:0] disp;
	} odc_slot_t;

	typedef struct packed {
		odc_state_t state;
		odc_slot_t [NSLOT-1:0] slot;
		logic [NSLOT-1:0] taken;
	} odc_regs_t;

	odc_regs_t r_q, r_d;
	odc_slot_t [NSLOT-1:0] dec;

	function automatic logic [7:0] unit_of(input odc_optype_t t);
		unique case (t)
			OPT_ALU:                           unit_of = UNIT_ANY_INT;
			OPT_ALUX:                          unit_of = UNIT_INTX;
			OPT_LIMM:                          unit_of = UNIT_ICU;
			OPT_LOAD, OPT_FLOAD, OPT_MLOAD:    unit_of = UNIT_LOAD;
			OPT_STORE, OPT_FSTORE, OPT_MSTORE: unit_of = UNIT_STORE;
			OPT_BRANCH:                        unit_of = UNIT_BRU;
			OPT_FLOAT:                         unit_of = UNIT_FPU;
			OPT_MEU:                           unit_of = UNIT_MEU;
			default:                           unit_of = UNIT_NONE;
		endcase
	endfunction

	// Little-endian field of n bytes from position p
	function automatic logic [31:0] get_le(input logic [BYTES_W*8-1:0] b, input int p, input int n);
		logic [31:0] v;
		v = 32'h0;
		for (int i = 0; i < 4; i++) begin
			if (i < n && p + i < BYTES_W)
				v[i*8 +: 8] = b[(p+i)*8 +: 8];
		end
		get_le = v;
	endfunction

	function automatic odc_slot_t decode(input logic [BYTES_W*8-1:0] b, input logic os32, input logic as32);
		odc_slot_t s;
		logic [7:0] op;
		logic [7:0] m;
		logic       mem;
		logic       has_m;
		logic       load_src;
		logic       x8;
		int         ipos;
		int         dlen;
		int         ilen;
		s = '0;
		op = b[7:0];
		m = b[15:8];
		s.cls = CLS_NONE;
		for (int k = 0; k < NUM_OPS; k++) begin
			s.ops[k] = OPT_NONE;
		end
		mem = (m[MOD_HI:MOD_LO] != MOD_REG);
		has_m = 1'b0;
		load_src = 1'b0;
		x8 = 1'b0;
		ilen = 0;
		dlen = 0;
		s.unrec = 1'b0;
		if (op == OP_AAA || op == OP_AAS) begin
			s.cls = CLS_VECTOR;
		end else if ((op == OP_AAD || op == OP_AAM) && m == OP_ADJ_SUB) begin
			s.cls = CLS_VECTOR;
		end else if (op >= 8'h10 && op <= 8'h13) begin
			has_m = 1'b1;
			s.cls = CLS_VECTOR;
		end else if (op == 8'h14 || op == 8'h15) begin
			s.cls = CLS_VECTOR;
			ilen = (op == 8'h14) ? 1 : (os32 ? 4 : 2);
		end else if ((op >= 8'h00 && op <= 8'h03) || (op >= 8'h20 && op <= 8'h23)) begin
			has_m = 1'b1;
			x8 = ~op[0];
			load_src = op[1];
		end else if (op == 8'h04 || op == 8'h05 || op == 8'h24) begin
			x8 = ~op[0];
			ilen = op[0] ? (os32 ? 4 : 2) : 1;
			s.cls = CLS_SHORT;
			s.ops[0] = x8 ? OPT_ALUX : OPT_ALU;
		end else if (op == OP_GRP_B || op == OP_GRP_V || op == OP_GRP_S) begin
			has_m = 1'b1;
			ilen = (op == OP_GRP_V) ? (os32 ? 4 : 2) : 1;
			x8 = (op != OP_GRP_V);
			if (m[REG_HI:REG_LO] == REG_ADC)
				s.cls = CLS_VECTOR;
			else if (m[REG_HI:REG_LO] != REG_ADD && m[REG_HI:REG_LO] != REG_AND)
				s.unrec = 1'b1;
		end else begin
			s.unrec = 1'b1;
		end
		// Non-vector modR/M forms
		if (has_m && s.cls == CLS_NONE && !s.unrec) begin
			if (!mem) begin
				s.cls = CLS_SHORT;
				s.ops[0] = x8 ? OPT_ALUX : OPT_ALU;
			end else if (load_src) begin
				s.cls = CLS_SHORT;
				s.ops[0] = OPT_LOAD;
				s.ops[1] = x8 ? OPT_ALUX : OPT_ALU;
			end else begin
				s.cls = CLS_LONG;
				s.ops[0] = OPT_LOAD;
				s.ops[1] = x8 ? OPT_ALUX : OPT_ALU;
				s.ops[2] = OPT_STORE;
			end
		end
		if (has_m) begin
			s.mem = mem;
			s.rf = m[REG_HI:REG_LO];
			s.rs = m[RM_HI:RM_LO];
			if (mem) begin
				if (m[MOD_HI:MOD_LO] == MOD_D8)
					dlen = 1;
				else if (m[MOD_HI:MOD_LO] == MOD_DFULL)
					dlen = as32 ? 4 : 2;
				else if (as32 ? (m[RM_HI:RM_LO] == 3'h5) : (m[RM_HI:RM_LO] == 3'h6))
					dlen = as32 ? 4 : 2;
			end
		end
		// SIB byte follows modR/M for 32-bit memory forms with rm 100
		ipos = has_m ? (2 + ((mem && as32 && m[RM_HI:RM_LO] == 3'h4) ? 1 : 0)) : 1;
		s.disp = get_le(b, ipos, dlen);
		if (dlen == 1)
			s.disp = {{24{s.disp[7]}}, s.disp[7:0]};
		s.imm = get_le(b, ipos + dlen, ilen);
		if (op == OP_GRP_S)
			s.imm = {{24{s.imm[7]}}, s.imm[7:0]};
		for (int k = 0; k < NUM_OPS; k++) begin
			s.units[k] = unit_of(s.ops[k]);
		end
		s.vld = 1'b1;
		decode = s;
	endfunction

	for (genvar g = 0; g < NSLOT; g++) begin : g_dec
		assign dec[g] = decode(IN_BYTES[g], OP_SIZE32[g], ADDR_SIZE32[g]);
	end

	always_comb begin
		r_d = r_q;
		r_d.taken = '0;
		// Unaccepted outputs stay put until the scheduler takes them
		if (OUT_READY || r_q.state == ST_IDLE) begin
			r_d.state = ST_IDLE;
			for (int k = 0; k < NSLOT; k++) begin
				r_d.slot[k] = '0;
			end
			if (IN_VALID[0]) begin
				r_d.state = ST_ISSUE;
				r_d.slot[0] = dec[0];
				r_d.taken[0] = 1'b1;
				// Pair only two short decodes
				if (NSLOT > 1 && IN_VALID[1] && dec[0].cls == CLS_SHORT
					&& dec[1].cls == CLS_SHORT) begin
					r_d.slot[1] = dec[1];
					r_d.taken[1] = 1'b1;
				end
			end
		end
		if (r_d.state == ST_ISSUE && !OUT_READY)
			r_d.state = ST_HOLD;
		if (r_q.state == ST_HOLD && !OUT_READY)
			r_d.state = ST_HOLD;
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			r_q <= '0;
			r_q.state <= ST_IDLE;
		end else begin
			r_q <= r_d;
		end
	end

	for (genvar g = 0; g < NSLOT; g++) begin : g_out
		assign OUT_VALID[g]      = r_q.slot[g].vld;
		assign OUT_CLASS[g]      = r_q.slot[g].cls;
		assign OUT_OPS[g]        = r_q.slot[g].ops;
		assign OUT_UNITS[g]      = r_q.slot[g].units;
		assign OUT_UNRECOG[g]    = r_q.slot[g].unrec;
		assign OUT_MEMFORM[g]    = r_q.slot[g].mem;
		assign OUT_REG_FIRST[g]  = r_q.slot[g].rf;
		assign OUT_REG_SECOND[g] = r_q.slot[g].rs;
		assign OUT_IMM[g]        = r_q.slot[g].imm;
		assign OUT_DISP[g]       = r_q.slot[g].disp;
	end
	assign TAKEN     = r_q.taken;
	assign OUT_STATE = r_q.state;
endmodule

// ==== verilog/odc_pkg.sv ====
// Constants and types of the opcode decode classifier
package odc_pkg;
	localparam int          BYTES_W     = 16;
	localparam logic [7:0]  OP_AAA      = 8'h37;
	localparam logic [7:0]  OP_AAS      = 8'h3f;
	localparam logic [7:0]  OP_AAD      = 8'hd5;
	localparam logic [7:0]  OP_AAM      = 8'hd4;
	localparam logic [7:0]  OP_ADJ_SUB  = 8'h0a;
	localparam logic [7:0]  OP_GRP_B    = 8'h80;
	localparam logic [7:0]  OP_GRP_V    = 8'h81;
	localparam logic [7:0]  OP_GRP_S    = 8'h83;
	localparam logic [2:0]  REG_ADD     = 3'h0;
	localparam logic [2:0]  REG_AND     = 3'h4;
	localparam logic [2:0]  REG_ADC     = 3'h2;
	localparam logic [1:0]  MOD_REG     = 2'h3;
	localparam logic [1:0]  MOD_D8      = 2'h1;
	localparam logic [1:0]  MOD_DFULL   = 2'h2;
	localparam int          MOD_HI      = 7;
	localparam int          MOD_LO      = 6;
	localparam int          REG_HI      = 5;
	localparam int          REG_LO      = 3;
	localparam int          RM_HI       = 2;
	localparam int          RM_LO       = 0;
	localparam int          NUM_OPS     = 3;

	typedef enum logic [1:0] {
		CLS_NONE   = 2'h0,
		CLS_SHORT  = 2'h1,
		CLS_LONG   = 2'h2,
		CLS_VECTOR = 2'h3
	} odc_class_t;

	typedef enum logic [3:0] {
		OPT_NONE   = 4'h0,
		OPT_ALU    = 4'h1,
		OPT_ALUX   = 4'h2,
		OPT_BRANCH = 4'h3,
		OPT_FLOAT  = 4'h4,
		OPT_LIMM   = 4'h5,
		OPT_LOAD   = 4'h6,
		OPT_FLOAD  = 4'h7,
		OPT_MLOAD  = 4'h8,
		OPT_MEU    = 4'h9,
		OPT_STORE  = 4'ha,
		OPT_FSTORE = 4'hb,
		OPT_MSTORE = 4'hc
	} odc_optype_t;

	// One-hot unit routing
	typedef enum logic [7:0] {
		UNIT_NONE  = 8'h00,
		UNIT_INTX  = 8'h01,
		UNIT_INTY  = 8'h02,
		UNIT_ICU   = 8'h04,
		UNIT_LOAD  = 8'h08,
		UNIT_STORE = 8'h10,
		UNIT_BRU   = 8'h20,
		UNIT_FPU   = 8'h40,
		UNIT_MEU   = 8'h80
	} odc_unit_t;

	localparam logic [7:0] UNIT_ANY_INT = 8'h03;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_ISSUE = 3'b010,
		ST_HOLD  = 3'b100
	} odc_state_t;
endpackage
